// File: rtl/stx_scan_xcvr.sv
`timescale 1ns/1ps
`include "stx_map.svh"
// Overview of operation
// RULE1: ce and le low pass A transparently
// RULE2: either enable high holds latched A
// RULE3: B driven only when oe, ce low
// RULE4: B-to-A path mirrors A-to-B controls
// RULE5: latch closed keeps previous B level
// RULE6: test mode hands pins to scan cells
// RULE7: normal instructions leave transceiver untouched
// RULE8: sample on tck rise, outputs on fall
// RULE9: controller steers states through tms levels
// RULE10: tdi to tdo through ir or dr
// RULE11: ir 8, bsr 40, bcr 11, bypass 1
// RULE12: signature analysis, masking, pattern generation
// RULE13: two scan cells per data pin
// RULE14: tms high reaches reset in five clocks
// RULE15: tap reset: ir ones, bsr zero
// RULE16: tap reset: bcr selects unmasked signature
// RULE17: capture-ir loads fixed status pattern
// RULE18: bypass captures zero, one-stage delay
module stx_scan_xcvr (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic TCK,
   input wire logic TMS,
   input wire logic TDI,
   output logic TDO,
   output logic TDO_OE_N,
   input wire stx_pkg::stx_ctl_t CTL_N,
   input wire logic [7:0] A_I,
   output logic [7:0] A_O,
   output logic A_OE_N,
   input wire logic [7:0] B_I,
   output logic [7:0] B_O,
   output logic B_OE_N
);
   // registered state: 8-bit ir, 40-bit bsr and 11-bit bcr with shadows, 1-bit bypass
   stx_pkg::stx_state_t r; // RULE11
   stx_pkg::stx_state_t next_r; // next state
   logic tck_rise; // tck rising edge seen this cycle
   logic tck_fall; // tck falling edge seen this cycle
   logic tmode; // test mode active
   stx_pkg::stx_dr_t dsel; // selected data register
   logic [39:0] cap_vec; // pin snapshot for capture-dr
   logic [7:0] psa_in; // masked signature input

   // tap state transition on the sampled tms level
   function automatic stx_pkg::stx_tap_t tap_next(input stx_pkg::stx_tap_t s,
                                                 input logic m);
      unique case (s)
         stx_pkg::ST_TLR: tap_next = m ? stx_pkg::ST_TLR : stx_pkg::ST_RTI;
         stx_pkg::ST_RTI: tap_next = m ? stx_pkg::ST_SEL_DR : stx_pkg::ST_RTI;
         stx_pkg::ST_SEL_DR: tap_next = m ? stx_pkg::ST_SEL_IR : stx_pkg::ST_CAP_DR;
         stx_pkg::ST_CAP_DR: tap_next = m ? stx_pkg::ST_EX1_DR : stx_pkg::ST_SH_DR;
         stx_pkg::ST_SH_DR: tap_next = m ? stx_pkg::ST_EX1_DR : stx_pkg::ST_SH_DR;
         stx_pkg::ST_EX1_DR: tap_next = m ? stx_pkg::ST_UPD_DR : stx_pkg::ST_PA_DR;
         stx_pkg::ST_PA_DR: tap_next = m ? stx_pkg::ST_EX2_DR : stx_pkg::ST_PA_DR;
         stx_pkg::ST_EX2_DR: tap_next = m ? stx_pkg::ST_UPD_DR : stx_pkg::ST_SH_DR;
         stx_pkg::ST_UPD_DR: tap_next = m ? stx_pkg::ST_SEL_DR : stx_pkg::ST_RTI;
         stx_pkg::ST_SEL_IR: tap_next = m ? stx_pkg::ST_TLR : stx_pkg::ST_CAP_IR;
         stx_pkg::ST_CAP_IR: tap_next = m ? stx_pkg::ST_EX1_IR : stx_pkg::ST_SH_IR;
         stx_pkg::ST_SH_IR: tap_next = m ? stx_pkg::ST_EX1_IR : stx_pkg::ST_SH_IR;
         stx_pkg::ST_EX1_IR: tap_next = m ? stx_pkg::ST_UPD_IR : stx_pkg::ST_PA_IR;
         stx_pkg::ST_PA_IR: tap_next = m ? stx_pkg::ST_EX2_IR : stx_pkg::ST_PA_IR;
         stx_pkg::ST_EX2_IR: tap_next = m ? stx_pkg::ST_UPD_IR : stx_pkg::ST_SH_IR;
         stx_pkg::ST_UPD_IR: tap_next = m ? stx_pkg::ST_SEL_DR : stx_pkg::ST_RTI;
      endcase
   endfunction

   // 8-bit lfsr step folded with parallel data, shared by signature and pattern
   function automatic logic [7:0] lfsr8(input logic [7:0] s, input logic [7:0] d);
      lfsr8 = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]} ^ d;
   endfunction

   // instructions that take the pins away from the transceiver
   function automatic logic is_test(input logic [7:0] op);
      is_test = (op == `STX_OP_EXTEST) || (op == `STX_OP_HIGHZ) ||
                (op == `STX_OP_CLAMP) || (op == `STX_OP_RUNT);
   endfunction

   // edge finding on the synchronised test clock
   assign tck_rise = r.tck_s2 & ~r.tck_d;
   assign tck_fall = ~r.tck_s2 & r.tck_d;
   // the reset state always means normal function, whatever the ir holds
   assign tmode = (r.tap != stx_pkg::ST_TLR) && is_test(r.ir);
   // unknown opcodes fall back to bypass
   assign dsel = (r.ir == `STX_OP_EXTEST || r.ir == `STX_OP_SAMPLE) ? stx_pkg::DR_BSR :
                 (r.ir == `STX_OP_SCANCN) ? stx_pkg::DR_BCR : stx_pkg::DR_BYPASS;
   // two cells per data pin: inputs observed apart from output control
   assign cap_vec = {r.b_drv, r.a_drv, r.ctl_s2, r.b_out, r.b_s2, r.a_out, r.a_s2}; // RULE13
   // masked bits do not disturb the signature
   assign psa_in = (r.boundary_control_register[1:0] == `STX_BCR_OP_PSAM) ?
                   (r.b_s2 & ~r.boundary_control_register[10:3]) : r.b_s2; // RULE12

   // all next-state logic
   always_comb begin
      next_r = r;
      // two-flop synchronisers for every pin input except the clock and RST_N
      next_r.tck_s1 = TCK;
      next_r.tck_s2 = r.tck_s1;
      next_r.tck_d = r.tck_s2;
      next_r.tms_s1 = TMS;
      next_r.tms_s2 = r.tms_s1;
      next_r.tdi_s1 = TDI;
      next_r.tdi_s2 = r.tdi_s1;
      next_r.ctl_s1 = CTL_N;
      next_r.ctl_s2 = r.ctl_s1;
      next_r.a_s1 = A_I;
      next_r.a_s2 = r.a_s1;
      next_r.b_s1 = B_I;
      next_r.b_s2 = r.b_s1;

      // transceiver latches, frozen while test mode owns the pins
      if (!tmode) begin // RULE6 RULE7
         if (!r.ctl_s2.a_to_b_chip_enable_n && !r.ctl_s2.a_to_b_latch_enable_n) begin
            next_r.ab_lat = r.a_s2; // RULE1
         end
         // otherwise ab_lat keeps its value, so B holds its old level
         if (!r.ctl_s2.b_to_a_chip_enable_n && !r.ctl_s2.b_to_a_latch_enable_n) begin
            next_r.ba_lat = r.b_s2; // RULE4
         end
      end // RULE2 RULE5

      // pin drivers: scan cells in test mode, latches otherwise
      if (tmode) begin // RULE6
         if (r.ir == `STX_OP_HIGHZ) begin
            next_r.a_drv = 1'b0;
            next_r.b_drv = 1'b0;
         end else begin
            next_r.a_drv = r.bsr_upd[`STX_BS_OEA];
            next_r.b_drv = r.bsr_upd[`STX_BS_OEB];
         end
         next_r.a_out = r.bsr_upd[`STX_BS_AO_LSB +: 8];
         next_r.b_out = r.bsr_upd[`STX_BS_BO_LSB +: 8];
      end else begin
         next_r.b_out = r.ab_lat;
         next_r.b_drv = ~(r.ctl_s2.a_to_b_output_enable_n |
                          r.ctl_s2.a_to_b_chip_enable_n); // RULE3
         next_r.a_out = r.ba_lat;
         next_r.a_drv = ~(r.ctl_s2.b_to_a_output_enable_n |
                          r.ctl_s2.b_to_a_chip_enable_n); // RULE4
      end

      // rising tck: sample tms and tdi, capture and shift
      if (tck_rise) begin // RULE8
         unique case (r.tap)
            stx_pkg::ST_CAP_DR: begin
               unique case (dsel)
                  stx_pkg::DR_BSR: next_r.boundary_scan_chain = cap_vec;
                  stx_pkg::DR_BCR: next_r.bcr_sh = r.boundary_control_register;
                  stx_pkg::DR_BYPASS: next_r.byp = 1'b0; // RULE18
               endcase
            end
            stx_pkg::ST_SH_DR: begin
               unique case (dsel) // RULE10
                  stx_pkg::DR_BSR: next_r.boundary_scan_chain = {r.tdi_s2, r.boundary_scan_chain[39:1]};
                  stx_pkg::DR_BCR: next_r.bcr_sh = {r.tdi_s2, r.bcr_sh[10:1]};
                  stx_pkg::DR_BYPASS: next_r.byp = r.tdi_s2; // RULE18
               endcase
            end
            stx_pkg::ST_CAP_IR: next_r.ir_sh = `STX_IR_CAPTURE; // RULE17
            stx_pkg::ST_SH_IR: next_r.ir_sh = {r.tdi_s2, r.ir_sh[7:1]}; // RULE10
            stx_pkg::ST_RTI: begin
               // self-test runs one step per tck while idling
               if (r.ir == `STX_OP_RUNT) begin // RULE12
                  if (r.boundary_control_register[1] == 1'b1) begin
                     next_r.bsr_upd[`STX_BS_AO_LSB +: 8] =
                        lfsr8(r.bsr_upd[`STX_BS_AO_LSB +: 8], psa_in);
                  end else if (r.boundary_control_register[1:0] == `STX_BCR_OP_PSEUDO_RANDOM_PATTERN_GEN) begin
                     next_r.bsr_upd[`STX_BS_BO_LSB +: 8] =
                        lfsr8(r.bsr_upd[`STX_BS_BO_LSB +: 8], 8'h00);
                  end
               end
            end
            default: begin
               // remaining states do no register work
            end
         endcase
         // tms high walks every path back to reset within five steps
         next_r.tap = tap_next(r.tap, r.tms_s2); // RULE9 RULE14
      end

      // falling tck: updates and tdo change
      if (tck_fall) begin // RULE8
         if (r.tap == stx_pkg::ST_UPD_IR) begin
            next_r.ir = r.ir_sh;
         end
         if (r.tap == stx_pkg::ST_UPD_DR && dsel == stx_pkg::DR_BSR) begin
            next_r.bsr_upd = r.boundary_scan_chain;
         end
         if (r.tap == stx_pkg::ST_UPD_DR && dsel == stx_pkg::DR_BCR) begin
            next_r.boundary_control_register = r.bcr_sh;
         end
         next_r.tdo_drv = (r.tap == stx_pkg::ST_SH_IR) || (r.tap == stx_pkg::ST_SH_DR);
         if (r.tap == stx_pkg::ST_SH_IR) begin // RULE10
            next_r.tdo = r.ir_sh[0];
         end else if (dsel == stx_pkg::DR_BSR) begin
            next_r.tdo = r.boundary_scan_chain[0];
         end else if (dsel == stx_pkg::DR_BCR) begin
            next_r.tdo = r.bcr_sh[0];
         end else begin
            next_r.tdo = r.byp;
         end
      end

      // test-logic reset forces the documented register values
      if (r.tap == stx_pkg::ST_TLR) begin
         next_r.ir = `STX_IR_RESET; // RULE15
         next_r.boundary_scan_chain = '0; // RULE15
         next_r.bsr_upd = '0; // RULE15
         next_r.boundary_control_register = `STX_BCR_RESET; // RULE16
      end
   end

   // single state register; reset clears all but the control syncs, tap lands in its reset state
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         r <= '0;
         // control syncs start at the disabled level, so no bus is driven as reset ends
         r.ctl_s1 <= '1;
         r.ctl_s2 <= '1;
      end else begin
         r <= next_r;
      end
   end

   // outputs straight from state; enables are active low while driving
   assign TDO = r.tdo;
   assign TDO_OE_N = ~r.tdo_drv;
   assign A_O = r.a_out;
   assign A_OE_N = ~r.a_drv;
   assign B_O = r.b_out;
   assign B_OE_N = ~r.b_drv;
endmodule

// File: common/stx_map.svh
`ifndef STX_MAP_SVH
`define STX_MAP_SVH
// register widths
`define STX_IR_W 8
`define STX_BSR_W 40
`define STX_BCR_W 11
// reset and capture values
`define STX_IR_RESET 8'hff
`define STX_IR_CAPTURE 8'h81
`define STX_BCR_RESET 11'h002
// instruction opcodes, all even parity
`define STX_OP_EXTEST 8'h00
`define STX_OP_SAMPLE 8'h82
`define STX_OP_HIGHZ 8'h06
`define STX_OP_CLAMP 8'h87
`define STX_OP_RUNT 8'h09
`define STX_OP_SCANCN 8'h8e
// boundary-scan field positions
`define STX_BS_AI_LSB 0
`define STX_BS_AO_LSB 8
`define STX_BS_BI_LSB 16
`define STX_BS_BO_LSB 24
`define STX_BS_CTL_LSB 32
`define STX_BS_OEA 38
`define STX_BS_OEB 39
// boundary-control fields
`define STX_BCR_OP_LSB 0
`define STX_BCR_MASK_LSB 3
`define STX_BCR_OP_NONE 2'h0
`define STX_BCR_OP_PSEUDO_RANDOM_PATTERN_GEN 2'h1
`define STX_BCR_OP_PSA 2'h2
`define STX_BCR_OP_PSAM 2'h3
`endif

// File: common/stx_pkg.sv
package stx_pkg;
   // tap controller states, reset state coded zero
   typedef enum logic [3:0] {
      ST_TLR = 4'h0, ST_RTI = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
      ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PA_DR = 4'h6, ST_EX2_DR = 4'h7,
      ST_UPD_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'ha, ST_SH_IR = 4'hb,
      ST_EX1_IR = 4'hc, ST_PA_IR = 4'hd, ST_EX2_IR = 4'he, ST_UPD_IR = 4'hf
   } stx_tap_t;
   // data register selected for scan
   typedef enum logic [1:0] {
      DR_BYPASS = 2'h0, DR_BSR = 2'h1, DR_BCR = 2'h2
   } stx_dr_t;
   // transceiver control pins, all active low
   typedef struct packed {
      logic a_to_b_chip_enable_n;
      logic a_to_b_output_enable_n;
      logic a_to_b_latch_enable_n;
      logic b_to_a_chip_enable_n;
      logic b_to_a_output_enable_n;
      logic b_to_a_latch_enable_n;
   } stx_ctl_t;
   // whole module state
   typedef struct packed {
      logic tck_s1, tck_s2, tck_d;
      logic tms_s1, tms_s2, tdi_s1, tdi_s2;
      stx_ctl_t ctl_s1, ctl_s2;
      logic [7:0] a_s1, a_s2, b_s1, b_s2;
      stx_tap_t tap;
      logic [7:0] ir_sh, ir;
      logic [39:0] boundary_scan_chain, bsr_upd;
      logic [10:0] bcr_sh, boundary_control_register;
      logic byp;
      logic tdo, tdo_drv;
      logic [7:0] ab_lat, ba_lat;
      logic [7:0] a_out, b_out;
      logic a_drv, b_drv;
   } stx_state_t;
endpackage

// File: testbench/stx_scan_xcvr_properties.sv
`timescale 1ns/1ps
module stx_scan_xcvr_properties (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic TCK,
   input wire logic TDO,
   input wire logic TDO_OE_N,
   input wire stx_pkg::stx_ctl_t CTL_N,
   input wire logic [7:0] A_I,
   input wire logic [7:0] A_O,
   input wire logic A_OE_N,
   input wire logic [7:0] B_I,
   input wire logic [7:0] B_O,
   input wire logic B_OE_N
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   // latch open and bus enable per direction, pin levels
   wire ab_open = !CTL_N.a_to_b_chip_enable_n && !CTL_N.a_to_b_latch_enable_n;
   wire ba_open = !CTL_N.b_to_a_chip_enable_n && !CTL_N.b_to_a_latch_enable_n;
   wire ab_on = !CTL_N.a_to_b_chip_enable_n && !CTL_N.a_to_b_output_enable_n;
   wire ba_on = !CTL_N.b_to_a_chip_enable_n && !CTL_N.b_to_a_output_enable_n;
   // the past-reset guard keeps stale sync stages out of the window
   reset_quiet_a: assert property ($rose(RST_N) |-> (A_OE_N && B_OE_N && TDO_OE_N) [*3])
      else $error("a bus is driven right after reset");
   b_enable_a: assert property ($past(RST_N,6) && !B_OE_N |-> $past(ab_on,3))
      else $error("b driven without its enables");
   a_enable_a: assert property ($past(RST_N,6) && !A_OE_N |-> $past(ba_on,3))
      else $error("a driven without its enables");
   b_follow_a: assert property ($past(RST_N,6) && !B_OE_N && $past(ab_open,4) && $past(ab_open,5)
      && $past(A_I,3) == $past(A_I,5) && $past(A_I,4) == $past(A_I,5) |-> B_O == $past(A_I,4))
      else $error("b does not follow a");
   a_follow_a: assert property ($past(RST_N,6) && !A_OE_N && $past(ba_open,4) && $past(ba_open,5)
      && $past(B_I,3) == $past(B_I,5) && $past(B_I,4) == $past(B_I,5) |-> A_O == $past(B_I,4))
      else $error("a does not follow b");
   b_hold_a: assert property ($past(RST_N,6) && !B_OE_N && !$past(B_OE_N) && !$past(ab_open,3)
      && !$past(ab_open,4) && !$past(ab_open,5) |-> $stable(B_O))
      else $error("b changed while latched");
   a_hold_a: assert property ($past(RST_N,6) && !A_OE_N && !$past(A_OE_N) && !$past(ba_open,3)
      && !$past(ba_open,4) && !$past(ba_open,5) |-> $stable(A_O))
      else $error("a changed while latched");
   tdo_fall_a: assert property ($changed(TDO) || $changed(TDO_OE_N) |-> !$past(TCK) && !$past(TCK,2))
      else $error("tdo moved outside the low phase");
   cover property (!B_OE_N && $past(ab_open,4));
   cover property (!A_OE_N && $past(ba_open,4));
   cover property ($fell(TDO_OE_N));
endmodule
bind stx_scan_xcvr stx_scan_xcvr_properties i_props (.REF_CLK(REF_CLK), .RST_N(RST_N),
   .TCK(TCK), .TDO(TDO), .TDO_OE_N(TDO_OE_N), .CTL_N(CTL_N), .A_I(A_I), .A_O(A_O),
   .A_OE_N(A_OE_N), .B_I(B_I), .B_O(B_O), .B_OE_N(B_OE_N));

// File: testbench/stx_tap_master.sv
`timescale 1ns/1ps
module stx_tap_master (
   input wire logic REF_CLK,
   output logic TCK,
   output logic TMS,
   output logic TDI,
   input wire logic TDO,
   input wire logic TDO_OE_N
);
   logic last = 1'b0; // last driven tdo level
   // a released tdo shows the inverse, so a stale level never passes
   wire tdo_line = TDO_OE_N ? ~last : TDO;
   initial begin
      TCK = 1'b0;
      TMS = 1'b1;
      TDI = 1'b1;
   end
   always @(posedge REF_CLK) if (!TDO_OE_N) last <= TDO;
   // one 800 ns tck period; tck idles low between frames
   task automatic step(input logic ms, input logic di, output logic q);
      TMS = ms;
      TDI = di;
      repeat (4) @(negedge REF_CLK);
      TCK = 1'b1;
      q = tdo_line;
      repeat (4) @(negedge REF_CLK);
      TCK = 1'b0;
   endtask
   // tms levels lsb first, tdi at its idle high
   task automatic walk(input logic [5:0] ms, input int n);
      logic q;
      for (int i = 0; i < n; i++)
         step(ms[i], 1'b1, q);
   endtask
   // shift lsb first, leave on the last bit, then update and idle
   task automatic scan(input int n, input logic [39:0] din, output logic [39:0] dout);
      logic q;
      dout = '0;
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      walk(6'h01, 2);
   endtask
   task automatic ir(input logic [7:0] op, output logic [7:0] cap);
      logic [39:0] d;
      walk(6'h03, 4);
      scan(8, {32'h0, op}, d);
      cap = d[7:0];
   endtask
   task automatic dr(input int n, input logic [39:0] din, output logic [39:0] dout);
      walk(6'h01, 3);
      scan(n, din, dout);
   endtask
endmodule

// File: testbench/stx_scan_xcvr_tb_top.sv
`timescale 1ns/1ps
`include "stx_map.svh"
module stx_scan_xcvr_tb_top;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic tck, tms, tdi, tdo, tdo_oe_n, a_oe_n, b_oe_n;
   stx_pkg::stx_ctl_t ctl_n = '1; // all enables off
   logic [7:0] a_ext = 8'h00, b_ext = 8'h00, a_o, b_o, cap;
   logic [39:0] d;
   // bus level: our drive unless the design holds the bus
   wire [7:0] a_i = (a_oe_n !== 1'b0) ? a_ext : a_o;
   wire [7:0] b_i = (b_oe_n !== 1'b0) ? b_ext : b_o;
   int n_errors = 0;
   int checked = 0;
   // controls, a, b, then expected b_oe_n, b, a_oe_n, a
   typedef struct packed {
      logic [5:0] ctl;
      logic [7:0] a, b;
      logic boe;
      logic [7:0] bo;
      logic aoe;
      logic [7:0] ao;
   } stx_row_t;
   stx_row_t rows [10] = '{
      '{6'h07, 8'h5a, 8'h00, 1'b0, 8'h5a, 1'b1, 8'h00},
      '{6'h0f, 8'hc3, 8'h00, 1'b0, 8'h5a, 1'b1, 8'h00},
      '{6'h17, 8'hc3, 8'h00, 1'b1, 8'h00, 1'b1, 8'h00},
      '{6'h07, 8'hc3, 8'h00, 1'b0, 8'hc3, 1'b1, 8'h00},
      '{6'h27, 8'h11, 8'h00, 1'b1, 8'h00, 1'b1, 8'h00},
      '{6'h0f, 8'h11, 8'h00, 1'b0, 8'hc3, 1'b1, 8'h00},
      '{6'h38, 8'h00, 8'ha5, 1'b1, 8'h00, 1'b0, 8'ha5},
      '{6'h39, 8'h00, 8'h3c, 1'b1, 8'h00, 1'b0, 8'ha5},
      '{6'h3a, 8'h00, 8'h3c, 1'b1, 8'h00, 1'b1, 8'h00},
      '{6'h07, 8'h5a, 8'h00, 1'b0, 8'h5a, 1'b1, 8'h00}
   };
   always #50 ref_clk = ~ref_clk;
   stx_scan_xcvr i_dut (.REF_CLK(ref_clk), .RST_N(rst_n), .TCK(tck), .TMS(tms), .TDI(tdi),
      .TDO(tdo), .TDO_OE_N(tdo_oe_n), .CTL_N(ctl_n), .A_I(a_i), .A_O(a_o), .A_OE_N(a_oe_n),
      .B_I(b_i), .B_O(b_o), .B_OE_N(b_oe_n));
   stx_tap_master i_tap (.REF_CLK(ref_clk), .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo),
      .TDO_OE_N(tdo_oe_n));
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic final_report;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // watchdog: the run needs about 1130 cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      final_report();
   end
   initial begin
      repeat (12) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge ref_clk);
      foreach (rows[i]) begin
         ctl_n = rows[i].ctl;
         a_ext = rows[i].a;
         b_ext = rows[i].b;
         repeat (8) @(negedge ref_clk);
         chk("b_oe_n", {7'h0, rows[i].boe}, {7'h0, b_oe_n});
         if (!rows[i].boe) chk("b_o", rows[i].bo, b_o);
         chk("a_oe_n", {7'h0, rows[i].aoe}, {7'h0, a_oe_n});
         if (!rows[i].aoe) chk("a_o", rows[i].ao, a_o);
      end
      // leave test-logic reset for idle, where every scan task starts
      i_tap.walk(6'h00, 1);
      // snapshot of the pins while the transceiver keeps running
      i_tap.ir(`STX_OP_SAMPLE, cap);
      chk("ir capture", 8'h81, cap);
      i_tap.dr(40, 40'h0, d);
      chk("bsr a in", 8'h5a, d[7:0]);
      chk("bsr b out", 8'h5a, d[31:24]);
      chk("bsr ctl", 8'h07, {2'h0, d[37:32]});
      a_ext = 8'h96;
      repeat (8) @(negedge ref_clk);
      chk("b_o sampled", 8'h96, b_o);
      // test mode releases the bus, tap reset gives it back
      i_tap.ir(`STX_OP_HIGHZ, cap);
      repeat (8) @(negedge ref_clk);
      chk("b_oe_n highz", 8'h01, {7'h0, b_oe_n});
      chk("tdo_oe_n idle", 8'h01, {7'h0, tdo_oe_n});
      i_tap.walk(6'h1f, 6);
      repeat (8) @(negedge ref_clk);
      chk("b_oe_n tap reset", 8'h00, {7'h0, b_oe_n});
      i_tap.dr(9, 40'h1a5, d);
      chk("bypass lead", 8'h00, {7'h0, d[0]});
      chk("bypass delay", 8'ha5, d[8:1]);
      // boundary-control register still holds its reset value; write the same back
      i_tap.ir(`STX_OP_SCANCN, cap);
      i_tap.dr(11, {29'h0, `STX_BCR_RESET}, d);
      chk("bcr low", 8'h02, d[7:0]);
      chk("bcr high", 8'h00, {5'h0, d[10:8]});
      // reset in mid-run: no bus driven until the controls pass the synchroniser
      rst_n = 1'b0;
      repeat (12) @(negedge ref_clk);
      rst_n = 1'b1;
      @(negedge ref_clk);
      chk("b_oe_n reset 1", 8'h01, {7'h0, b_oe_n});
      @(negedge ref_clk);
      chk("b_oe_n reset 2", 8'h01, {7'h0, b_oe_n});
      repeat (8) @(negedge ref_clk);
      chk("b_oe_n after reset", 8'h00, {7'h0, b_oe_n});
      chk("b_o after reset", 8'h96, b_o);
      final_report();
   end
endmodule
